// ==== gp_map.svh ====
// Register offsets, reset values, field positions and codes for ports C, D and E
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

`define GP_ADDR_W            8
`define GP_DATA_W            8
`define GP_PORT_C_W          6

`define GP_OFF_PORT_C_LATCH  8'h02
`define GP_OFF_PORT_D_LATCH  8'h03
`define GP_OFF_PORT_C_DIR    8'h06
`define GP_OFF_PORT_D_DIR    8'h07
`define GP_OFF_PORT_E_LATCH  8'h08
`define GP_OFF_PORT_E_DIR    8'h0c

`define GP_RST_DIR           8'h00
`define GP_RST_LATCH         8'h00
`define GP_RST_CLKEN         1'h0
`define GP_RST_RDATA         8'h00
`define GP_RD_UNMAPPED       8'h00

`define GP_BIT_CLKEN         7
`define GP_BIT_C_CLKPIN      2

// First converter channel that lands on port D pin 0
`define GP_CONV_CHAN_BASE    5'h08
`define GP_CONV_PINS         7

`define GP_BIT_D_TA_CLK      6
`define GP_BIT_D_TB_CLK      4
// Prescaler code selecting the external clock pin
`define GP_PRESC_EXT_CLK     3'h7

`define GP_BIT_E_SCK         7
`define GP_BIT_E_MOSI        6
`define GP_BIT_E_MISO        5
`define GP_BIT_E_SS          4
`define GP_BIT_E_TPIN1       3
`define GP_BIT_E_TPIN0       2
`define GP_BIT_E_RXD         1
`define GP_BIT_E_TXD         0

`define GP_ELS_GPIO          2'h0
`define GP_IDLE_SS           1'h1
`define GP_IDLE_RXD          1'h1
`define GP_IDLE_IN           1'h0

`endif

// ==== gp_pkg.sv ====
// Types shared by the port C, D and E logic
package gp_pkg;
  typedef logic [7:0] gp_byte_t;
  typedef logic [7:0] gp_addr_t;
  typedef logic [5:0] gp_cbits_t;

  typedef enum logic [1:0] {
    GP_FN_GPIO = 2'b00,
    GP_FN_IN   = 2'b01,
    GP_FN_OUT  = 2'b10
  } gp_fn_e;
endpackage

// ==== gp_ports_cde.sv ====
// Ports C, D and E: latches, direction control, read mux and peripheral overrides
`timescale 1ns/100ps
`default_nettype none
`include "gp_map.svh"

// Contract
// - Clock-out enable drives system clock on C2, ignoring its direction; reset clears it.
// - Direction bit 1 enables pin output buffer; 0 leaves pin a high-impedance input.
// - Reset clears all port C direction bits so every C pin is input.
// - Port C read returns latch for output pins, sampled pin level for inputs; C2 reads 0 while clock-out is enabled.
// - Latch writes store, except C2 while clock-out is enabled; an input pin is unaffected by the written value.
// - Converter-selected D pins 0..6 read 0 as input, latch as output.
// - Port D direction ignored on timer pins but still picks latch or 0 on read.
// - D6 and D4 feed timer A and B external clocks when prescaler selects them.
// - Reset clears all eight port D direction bits, making D pins inputs.
// - Port D read returns latch for output pins, pin level for input pins.
// - E7 is SPI clock, input as slave, output as master, GPIO when SPI off.
// - E6 and E5 carry SPI MOSI and MISO, GPIO whenever SPI is disabled.
// - E4 is slave select; GPIO if SPI off or master without mode fault.
// - E3 and E2 are timer channel pins or GPIO per edge/level select.
// - E1 is serial receive, E0 serial transmit; GPIO while serial is disabled.
// - Port E direction never overrides claimed pins, yet selects latch or pin read.
// - Reset clears all eight port E direction bits, making E pins inputs.
// - Port E read returns latch for output pins, pin level for input pins.
module gp_ports_cde (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire gp_pkg::gp_addr_t reg_addr,
  input  wire gp_pkg::gp_byte_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  gp_pkg::gp_byte_t reg_rdata,
  input  wire gp_pkg::gp_cbits_t pc_in,
  output var  gp_pkg::gp_cbits_t pc_out,
  output var  gp_pkg::gp_cbits_t pc_oe,
  input  wire gp_pkg::gp_byte_t pd_in,
  output var  gp_pkg::gp_byte_t pd_out,
  output var  gp_pkg::gp_byte_t pd_oe,
  input  wire gp_pkg::gp_byte_t pe_in,
  output var  gp_pkg::gp_byte_t pe_out,
  output var  gp_pkg::gp_byte_t pe_oe,
  input  wire logic [4:0]       converter_channel_select,
  input  wire logic [2:0]       timer_a_prescaler_select,
  input  wire logic [2:0]       timer_b_prescaler_select,
  output var  logic             timer_a_ext_clock,
  output var  logic             timer_b_ext_clock,
  input  wire logic             serial_periph_enable,
  input  wire logic             serial_periph_master,
  input  wire logic             mode_fault_enable,
  input  wire logic             spi_sck_out,
  input  wire logic             spi_mosi_out,
  input  wire logic             spi_miso_out,
  output var  logic             spi_sck_in,
  output var  logic             spi_mosi_in,
  output var  logic             spi_miso_in,
  output var  logic             spi_ss_in,
  input  wire logic [1:0]       edge_level_select_ch0,
  input  wire logic [1:0]       edge_level_select_ch1,
  input  wire logic [1:0]       timer_channel_drive,
  input  wire logic [1:0]       timer_channel_out,
  output var  logic [1:0]       timer_channel_in,
  input  wire logic             async_serial_enable,
  input  wire logic             async_serial_txd,
  output var  logic             async_serial_rxd
);
  import gp_pkg::*;

  // Register file state
  gp_cbits_t c_latch_reg;
  gp_cbits_t c_latch_next;
  gp_byte_t  d_latch_reg;
  gp_byte_t  d_latch_next;
  gp_byte_t  e_latch_reg;
  gp_byte_t  e_latch_next;
  gp_cbits_t c_dir_reg;
  gp_cbits_t c_dir_next;
  logic      clken_reg;
  logic      clken_next;
  gp_byte_t  d_dir_reg;
  gp_byte_t  d_dir_next;
  gp_byte_t  e_dir_reg;
  gp_byte_t  e_dir_next;
  gp_byte_t  rdata_reg;
  gp_byte_t  rdata_next;

  // Pin and peripheral side state
  gp_cbits_t c_out_reg;
  gp_cbits_t c_out_next;
  gp_cbits_t c_oe_reg;
  gp_cbits_t c_oe_next;
  gp_byte_t  d_out_reg;
  gp_byte_t  d_out_next;
  gp_byte_t  d_oe_reg;
  gp_byte_t  d_oe_next;
  gp_byte_t  e_out_reg;
  gp_byte_t  e_out_next;
  gp_byte_t  e_oe_reg;
  gp_byte_t  e_oe_next;
  logic      ta_clk_reg;
  logic      ta_clk_next;
  logic      tb_clk_reg;
  logic      tb_clk_next;
  logic      sck_in_reg;
  logic      sck_in_next;
  logic      mosi_in_reg;
  logic      mosi_in_next;
  logic      miso_in_reg;
  logic      miso_in_next;
  logic      ss_in_reg;
  logic      ss_in_next;
  logic [1:0] tpin_in_reg;
  logic [1:0] tpin_in_next;
  logic      rxd_reg;
  logic      rxd_next;

  // Pin claims
  gp_byte_t  d_claim;
  gp_byte_t  d_rd_view;
  gp_cbits_t c_rd_view;
  gp_byte_t  e_rd_view;
  gp_fn_e    e_fn [8];
  logic      ta_sel;
  logic      tb_sel;
  logic      spi_ss_used;
  logic [1:0] tpin_used;

  // One prescaler code hands a port D pin to its timer
  assign ta_sel = (timer_a_prescaler_select == `GP_PRESC_EXT_CLK);
  assign tb_sel = (timer_b_prescaler_select == `GP_PRESC_EXT_CLK);
  // Master without mode fault detection leaves slave select unused
  assign spi_ss_used = serial_periph_enable && !(serial_periph_master && !mode_fault_enable);
  assign tpin_used[0] = (edge_level_select_ch0 != `GP_ELS_GPIO);
  assign tpin_used[1] = (edge_level_select_ch1 != `GP_ELS_GPIO);

  // Per-pin read views for ports C, D and E, and claims for port D
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      logic conv_hit;
      logic tclk_hit;
      if (gi < `GP_CONV_PINS) begin : g_conv
        assign conv_hit = (converter_channel_select == (`GP_CONV_CHAN_BASE + 5'(gi)));
      end else begin : g_noconv
        assign conv_hit = 1'b0;
      end
      if (gi == `GP_BIT_D_TA_CLK) begin : g_ta
        assign tclk_hit = ta_sel;
      end else if (gi == `GP_BIT_D_TB_CLK) begin : g_tb
        assign tclk_hit = tb_sel;
      end else begin : g_notclk
        assign tclk_hit = 1'b0;
      end
      assign d_claim[gi] = conv_hit || tclk_hit;
      // Claimed pins read latch or 0, never the pin
      assign d_rd_view[gi] = d_dir_reg[gi] ? d_latch_reg[gi] : (d_claim[gi] ? 1'b0 : pd_in[gi]);
      assign e_rd_view[gi] = e_dir_reg[gi] ? e_latch_reg[gi] : pe_in[gi];
      if (gi < `GP_PORT_C_W) begin : g_c
        if (gi == `GP_BIT_C_CLKPIN) begin : g_clkpin
          assign c_rd_view[gi] = clken_reg ? 1'b0 :
                                 (c_dir_reg[gi] ? c_latch_reg[gi] : pc_in[gi]);
        end else begin : g_plain
          assign c_rd_view[gi] = c_dir_reg[gi] ? c_latch_reg[gi] : pc_in[gi];
        end
      end
    end
  endgenerate

  // Port E pin functions
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      e_fn[i] = GP_FN_GPIO;
    end
    if (serial_periph_enable) begin
      e_fn[`GP_BIT_E_SCK]  = serial_periph_master ? GP_FN_OUT : GP_FN_IN;
      e_fn[`GP_BIT_E_MOSI] = serial_periph_master ? GP_FN_OUT : GP_FN_IN;
      e_fn[`GP_BIT_E_MISO] = serial_periph_master ? GP_FN_IN : GP_FN_OUT;
    end
    if (spi_ss_used) begin
      e_fn[`GP_BIT_E_SS] = GP_FN_IN;
    end
    if (tpin_used[1]) begin
      e_fn[`GP_BIT_E_TPIN1] = timer_channel_drive[1] ? GP_FN_OUT : GP_FN_IN;
    end
    if (tpin_used[0]) begin
      e_fn[`GP_BIT_E_TPIN0] = timer_channel_drive[0] ? GP_FN_OUT : GP_FN_IN;
    end
    if (async_serial_enable) begin
      e_fn[`GP_BIT_E_RXD] = GP_FN_IN;
      e_fn[`GP_BIT_E_TXD] = GP_FN_OUT;
    end
  end

  // Register writes and read data
  always_comb begin
    c_latch_next = c_latch_reg;
    d_latch_next = d_latch_reg;
    e_latch_next = e_latch_reg;
    c_dir_next   = c_dir_reg;
    clken_next   = clken_reg;
    d_dir_next   = d_dir_reg;
    e_dir_next   = e_dir_reg;
    rdata_next   = rdata_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        `GP_OFF_PORT_C_LATCH: begin
          c_latch_next = reg_wdata[`GP_PORT_C_W-1:0];
          if (clken_reg) begin
            c_latch_next[`GP_BIT_C_CLKPIN] = c_latch_reg[`GP_BIT_C_CLKPIN];
          end
        end
        `GP_OFF_PORT_D_LATCH: d_latch_next = reg_wdata;
        `GP_OFF_PORT_E_LATCH: e_latch_next = reg_wdata;
        `GP_OFF_PORT_C_DIR: begin
          c_dir_next = reg_wdata[`GP_PORT_C_W-1:0];
          clken_next = reg_wdata[`GP_BIT_CLKEN];
        end
        `GP_OFF_PORT_D_DIR:   d_dir_next = reg_wdata;
        `GP_OFF_PORT_E_DIR:   e_dir_next = reg_wdata;
        default: begin
          // Unmapped writes change nothing
        end
      endcase
    end

    // Read data stand for exactly one cycle
    rdata_next = `GP_RST_RDATA;
    if (reg_rd) begin
      unique case (reg_addr)
        `GP_OFF_PORT_C_LATCH: rdata_next = {2'h0, c_rd_view};
        `GP_OFF_PORT_D_LATCH: rdata_next = d_rd_view;
        `GP_OFF_PORT_E_LATCH: rdata_next = e_rd_view;
        `GP_OFF_PORT_C_DIR:   rdata_next = {clken_reg, 1'h0, c_dir_reg};
        `GP_OFF_PORT_D_DIR:   rdata_next = d_dir_reg;
        `GP_OFF_PORT_E_DIR:   rdata_next = e_dir_reg;
        default:              rdata_next = `GP_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Latches have no documented reset; cleared for a known start
      c_latch_reg <= gp_cbits_t'(`GP_RST_LATCH);
      d_latch_reg <= `GP_RST_LATCH;
      e_latch_reg <= `GP_RST_LATCH;
      c_dir_reg   <= gp_cbits_t'(`GP_RST_DIR);
      clken_reg   <= `GP_RST_CLKEN;
      d_dir_reg   <= `GP_RST_DIR;
      e_dir_reg   <= `GP_RST_DIR;
      rdata_reg   <= `GP_RST_RDATA;
    end else begin
      c_latch_reg <= c_latch_next;
      d_latch_reg <= d_latch_next;
      e_latch_reg <= e_latch_next;
      c_dir_reg   <= c_dir_next;
      clken_reg   <= clken_next;
      d_dir_reg   <= d_dir_next;
      e_dir_reg   <= e_dir_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Pin drive and peripheral inputs
  always_comb begin
    c_out_next = c_latch_reg;
    c_oe_next  = c_dir_reg;
    if (clken_reg) begin
      c_oe_next[`GP_BIT_C_CLKPIN] = 1'b1;
    end
    d_out_next = d_latch_reg;
    d_oe_next  = d_dir_reg & ~d_claim;
    e_out_next = e_latch_reg;
    e_oe_next  = e_dir_reg;
    // Claimed pins follow the peripheral, whatever their direction bit
    for (int i = 0; i < 8; i++) begin
      if (e_fn[i] != GP_FN_GPIO) begin
        e_oe_next[i] = (e_fn[i] == GP_FN_OUT);
      end
    end

    // Peripheral values replace the latch only on pins they drive
    if (e_fn[`GP_BIT_E_SCK] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_SCK] = spi_sck_out;
    end
    if (e_fn[`GP_BIT_E_MOSI] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_MOSI] = spi_mosi_out;
    end
    if (e_fn[`GP_BIT_E_MISO] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_MISO] = spi_miso_out;
    end
    if (e_fn[`GP_BIT_E_TPIN1] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_TPIN1] = timer_channel_out[1];
    end
    if (e_fn[`GP_BIT_E_TPIN0] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_TPIN0] = timer_channel_out[0];
    end
    if (e_fn[`GP_BIT_E_TXD] == GP_FN_OUT) begin
      e_out_next[`GP_BIT_E_TXD] = async_serial_txd;
    end

    // Unclaimed peripheral inputs rest at their idle levels
    ta_clk_next  = ta_sel ? pd_in[`GP_BIT_D_TA_CLK] : `GP_IDLE_IN;
    tb_clk_next  = tb_sel ? pd_in[`GP_BIT_D_TB_CLK] : `GP_IDLE_IN;
    sck_in_next  = (e_fn[`GP_BIT_E_SCK] == GP_FN_IN) ? pe_in[`GP_BIT_E_SCK] : `GP_IDLE_IN;
    mosi_in_next = (e_fn[`GP_BIT_E_MOSI] == GP_FN_IN) ? pe_in[`GP_BIT_E_MOSI] : `GP_IDLE_IN;
    miso_in_next = (e_fn[`GP_BIT_E_MISO] == GP_FN_IN) ? pe_in[`GP_BIT_E_MISO] : `GP_IDLE_IN;
    ss_in_next   = spi_ss_used ? pe_in[`GP_BIT_E_SS] : `GP_IDLE_SS;
    // A driving channel still sees its own pin, as capture logic expects
    tpin_in_next[1] = tpin_used[1] ? pe_in[`GP_BIT_E_TPIN1] : `GP_IDLE_IN;
    tpin_in_next[0] = tpin_used[0] ? pe_in[`GP_BIT_E_TPIN0] : `GP_IDLE_IN;
    rxd_next     = async_serial_enable ? pe_in[`GP_BIT_E_RXD] : `GP_IDLE_RXD;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // All pins released and peripheral inputs idle in reset
      c_out_reg   <= gp_cbits_t'(`GP_RST_LATCH);
      c_oe_reg    <= gp_cbits_t'(`GP_RST_DIR);
      d_out_reg   <= `GP_RST_LATCH;
      d_oe_reg    <= `GP_RST_DIR;
      e_out_reg   <= `GP_RST_LATCH;
      e_oe_reg    <= `GP_RST_DIR;
      ta_clk_reg  <= `GP_IDLE_IN;
      tb_clk_reg  <= `GP_IDLE_IN;
      sck_in_reg  <= `GP_IDLE_IN;
      mosi_in_reg <= `GP_IDLE_IN;
      miso_in_reg <= `GP_IDLE_IN;
      ss_in_reg   <= `GP_IDLE_SS;
      tpin_in_reg <= {2{`GP_IDLE_IN}};
      rxd_reg     <= `GP_IDLE_RXD;
    end else begin
      c_out_reg   <= c_out_next;
      c_oe_reg    <= c_oe_next;
      d_out_reg   <= d_out_next;
      d_oe_reg    <= d_oe_next;
      e_out_reg   <= e_out_next;
      e_oe_reg    <= e_oe_next;
      ta_clk_reg  <= ta_clk_next;
      tb_clk_reg  <= tb_clk_next;
      sck_in_reg  <= sck_in_next;
      mosi_in_reg <= mosi_in_next;
      miso_in_reg <= miso_in_next;
      ss_in_reg   <= ss_in_next;
      tpin_in_reg <= tpin_in_next;
      rxd_reg     <= rxd_next;
    end
  end

  // The clock itself cannot pass a flip-flop; gated in after the output register
  // Limitation: the pin enable follows the enable bit one cycle late
  always_comb begin
    pc_out = c_out_reg;
    pc_out[`GP_BIT_C_CLKPIN] = clken_reg ? clk : c_out_reg[`GP_BIT_C_CLKPIN];
  end

  assign reg_rdata         = rdata_reg;
  assign pc_oe             = c_oe_reg;
  assign pd_out            = d_out_reg;
  assign pd_oe             = d_oe_reg;
  assign pe_out            = e_out_reg;
  assign pe_oe             = e_oe_reg;
  assign timer_a_ext_clock = ta_clk_reg;
  assign timer_b_ext_clock = tb_clk_reg;
  assign spi_sck_in        = sck_in_reg;
  assign spi_mosi_in       = mosi_in_reg;
  assign spi_miso_in       = miso_in_reg;
  assign spi_ss_in         = ss_in_reg;
  assign timer_channel_in  = tpin_in_reg;
  assign async_serial_rxd  = rxd_reg;
endmodule
`default_nettype wire

// ==== gp_ports_cde_checker.sv ====
// Assertions on the port C, D and E block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module gp_ports_cde_checker (
  input wire logic              clk,
  input wire logic              rstn,
  input wire gp_pkg::gp_addr_t  reg_addr,
  input wire gp_pkg::gp_byte_t  reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire gp_pkg::gp_byte_t  reg_rdata,
  input wire gp_pkg::gp_cbits_t pc_in,
  input wire gp_pkg::gp_cbits_t pc_oe,
  input wire gp_pkg::gp_byte_t  pd_in,
  input wire gp_pkg::gp_byte_t  pd_oe,
  input wire gp_pkg::gp_byte_t  pe_out,
  input wire gp_pkg::gp_byte_t  pe_oe,
  input wire logic [4:0]        converter_channel_select,
  input wire logic [2:0]        timer_a_prescaler_select,
  input wire logic              timer_a_ext_clock,
  input wire logic              async_serial_enable,
  input wire logic              async_serial_txd
);
  import gp_pkg::*;
  gp_byte_t dirc_reg;
  gp_byte_t dirc_next;
  // Shadow of the port C direction register, needed to judge reads and enables
  always_comb begin
    dirc_next = dirc_reg;
    if (reg_wr && reg_addr == 8'h06) begin
      dirc_next = reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dirc_reg <= 8'h00;
    end else begin
      dirc_reg <= dirc_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_c;
    reg_rd && reg_addr == 8'h02;
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  c_dir_a: assert property ({pc_oe[5:3], pc_oe[1:0]} ==
    {$past(dirc_reg[5:3]), $past(dirc_reg[1:0])}) else $error("port C enable wrong");
  clk_out_a: assert property (dirc_reg[7] |=> pc_oe[2])
    else $error("clock pin not driven");
  c_read_a: assert property (rd_c ##0 dirc_reg[7:0] == 8'h00 |=>
    reg_rdata == {2'b00, $past(pc_in)}) else $error("port C pin read wrong");
  clk_read_a: assert property (rd_c ##0 dirc_reg[7] |=> !reg_rdata[2])
    else $error("clock pin bit not zero");
  conv_pin_a: assert property (converter_channel_select == 5'h0e |=> !pd_oe[6])
    else $error("converter pin driven");
  ext_clk_a: assert property (timer_a_prescaler_select == 3'h7 |=>
    !pd_oe[6] && timer_a_ext_clock == $past(pd_in[6])) else $error("timer clock wrong");
  txd_pin_a: assert property (async_serial_enable |=> pe_oe[0] && !pe_oe[1] &&
    pe_out[0] == $past(async_serial_txd)) else $error("serial pins wrong");
endmodule
bind gp_ports_cde gp_ports_cde_checker chk_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pc_in(pc_in), .pc_oe(pc_oe), .pd_in(pd_in), .pd_oe(pd_oe), .pe_out(pe_out),
  .pe_oe(pe_oe), .converter_channel_select(converter_channel_select),
  .timer_a_prescaler_select(timer_a_prescaler_select), .timer_a_ext_clock(timer_a_ext_clock),
  .async_serial_enable(async_serial_enable), .async_serial_txd(async_serial_txd));
`default_nettype wire

// ==== gp_pin_model.sv ====
// Far-side pin model: each pin shows the block's drive or the outside level
`timescale 1ns/100ps
`default_nettype none
module gp_pin_model (
  input  wire gp_pkg::gp_cbits_t pc_out,
  input  wire gp_pkg::gp_cbits_t pc_oe,
  input  wire gp_pkg::gp_cbits_t ext_c,
  output wire gp_pkg::gp_cbits_t pc_in,
  input  wire gp_pkg::gp_byte_t  pd_out,
  input  wire gp_pkg::gp_byte_t  pd_oe,
  input  wire gp_pkg::gp_byte_t  ext_d,
  output wire gp_pkg::gp_byte_t  pd_in,
  input  wire gp_pkg::gp_byte_t  pe_out,
  input  wire gp_pkg::gp_byte_t  pe_oe,
  input  wire gp_pkg::gp_byte_t  ext_e,
  output wire gp_pkg::gp_byte_t  pe_in
);
  import gp_pkg::*;
  // Released pins take the outside level, so a latch write cannot leak out
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & ext_e);
endmodule
`default_nettype wire

// ==== gp_ports_cde_test.sv ====
// Self-checking bench for the port C, D and E block
`timescale 1ns/100ps
`default_nettype none
module gp_ports_cde_test;
  import gp_pkg::*;
  typedef struct packed {gp_addr_t la; gp_byte_t lat, dir, ext, exp, oe;} gp_row_s;
  gp_row_s rows [6] = '{'{8'h02, 8'h2d, 8'h0f, 8'h30, 8'h3d, 8'h0f},
    '{8'h02, 8'h00, 8'h3f, 8'h3f, 8'h00, 8'h3f}, '{8'h03, 8'ha5, 8'hf0, 8'h3c, 8'hac, 8'hf0},
    '{8'h03, 8'h5a, 8'h00, 8'hc3, 8'hc3, 8'h00}, '{8'h08, 8'h96, 8'hff, 8'h00, 8'h96, 8'hff},
    '{8'h08, 8'h69, 8'h0f, 8'hf0, 8'hf9, 8'h0f}};
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, spi_en = 1'b0, spi_mst = 1'b0;
  logic mf_en = 1'b0, sck_o = 1'b0, mosi_o = 1'b0, miso_o = 1'b0, ser_en = 1'b0, txd = 1'b0;
  logic ta_clk, tb_clk, sck_i, mosi_i, miso_i, ss_i, rxd;
  logic [4:0] conv = 5'h00;
  logic [2:0] ta_pre = 3'h0, tb_pre = 3'h0;
  logic [1:0] els0 = 2'h0, els1 = 2'h0, tdrv = 2'h0, tout = 2'h0, tin;
  gp_addr_t   reg_addr = 8'h00;
  gp_byte_t   reg_wdata = 8'h00, ext_d = 8'h00, ext_e = 8'h00;
  gp_byte_t   reg_rdata, pd_in, pd_out, pd_oe, pe_in, pe_out, pe_oe;
  gp_cbits_t  ext_c = 6'h15, pc_in, pc_out, pc_oe;
  int         failures = 0, n_checks = 0, cycles = 0;
  gp_ports_cde dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_in(pc_in), .pc_out(pc_out),
    .pc_oe(pc_oe), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pe_in(pe_in),
    .pe_out(pe_out), .pe_oe(pe_oe), .converter_channel_select(conv),
    .timer_a_prescaler_select(ta_pre), .timer_b_prescaler_select(tb_pre),
    .timer_a_ext_clock(ta_clk), .timer_b_ext_clock(tb_clk), .serial_periph_enable(spi_en),
    .serial_periph_master(spi_mst), .mode_fault_enable(mf_en), .spi_sck_out(sck_o),
    .spi_mosi_out(mosi_o), .spi_miso_out(miso_o), .spi_sck_in(sck_i), .spi_mosi_in(mosi_i),
    .spi_miso_in(miso_i), .spi_ss_in(ss_i), .edge_level_select_ch0(els0),
    .edge_level_select_ch1(els1), .timer_channel_drive(tdrv), .timer_channel_out(tout),
    .timer_channel_in(tin), .async_serial_enable(ser_en), .async_serial_txd(txd),
    .async_serial_rxd(rxd));
  gp_pin_model pins_u (.pc_out(pc_out), .pc_oe(pc_oe), .ext_c(ext_c), .pc_in(pc_in),
    .pd_out(pd_out), .pd_oe(pd_oe), .ext_d(ext_d), .pd_in(pd_in), .pe_out(pe_out),
    .pe_oe(pe_oe), .ext_e(ext_e), .pe_in(pe_in));
  always #4 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is about 140 cycles; the ceiling only cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input gp_byte_t got, input gp_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input gp_addr_t a, input gp_byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input gp_addr_t a, input gp_byte_t exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", reg_rdata, exp);
  endtask
  // Peripheral paths are registered: give them two edges, then look mid-cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rst_chk;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    chk("oe", {2'b00, pc_oe} | pd_oe | pe_oe, 8'h00);
    chk("idle", {6'h00, ss_i, rxd}, 8'h03);
    rstn <= 1'b1;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h02, {2'b00, ext_c});
  endtask
  initial begin
    rst_chk();
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    foreach (rows[i]) begin
      @(posedge clk);
      ext_c <= rows[i].ext[5:0];
      ext_d <= rows[i].ext;
      ext_e <= rows[i].ext;
      wr(rows[i].la, rows[i].lat);
      wr(rows[i].la + 8'h04, rows[i].dir);
      rd(rows[i].la, rows[i].exp);
      chk("oe", rows[i].la == 8'h02 ? {2'b00, pc_oe} :
        (rows[i].la == 8'h03 ? pd_oe : pe_oe), rows[i].oe);
      chk("out", rows[i].la == 8'h02 ? {2'b00, pc_out} :
        (rows[i].la == 8'h03 ? pd_out : pe_out),
        rows[i].la == 8'h02 ? {2'b00, rows[i].lat[5:0]} : rows[i].lat);
    end
    wr(8'h07, 8'hff);
    rd(8'h03, 8'h5a);
    @(posedge clk);
    conv <= 5'h0e;
    settle();
    chk("pd_oe", pd_oe, 8'hbf);
    rd(8'h03, 8'h5a);
    wr(8'h07, 8'h00);
    rd(8'h03, 8'hb0);
    @(posedge clk);
    conv <= 5'h00;
    ta_pre <= 3'h7;
    tb_pre <= 3'h7;
    ext_d <= 8'hff;
    wr(8'h07, 8'hff);
    settle();
    chk("pd_oe", pd_oe, 8'haf);
    chk("tclk", {6'h00, tb_clk, ta_clk}, 8'h03);
    @(posedge clk);
    ext_d <= 8'h00;
    settle();
    chk("tclk", {6'h00, tb_clk, ta_clk}, 8'h00);
    wr(8'h02, 8'h04);
    wr(8'h06, 8'h84);
    rd(8'h06, 8'h84);
    chk("pc_oe", {2'b00, pc_oe}, 8'h04);
    chk("mclk", {7'h00, pc_out[2]}, 8'h00);
    @(posedge clk);
    #1 chk("mclk", {7'h00, pc_out[2]}, 8'h01);
    rd(8'h02, 8'h30);
    wr(8'h02, 8'h00);
    wr(8'h06, 8'h04);
    rd(8'h02, 8'h34);
    wr(8'h0c, 8'h00);
    @(posedge clk);
    spi_en <= 1'b1;
    spi_mst <= 1'b1;
    sck_o <= 1'b1;
    ext_e <= 8'h20;
    settle();
    chk("pe_oe", pe_oe, 8'hc0);
    chk("spi", {pe_out[7:6], 5'h00, miso_i}, 8'h81);
    @(posedge clk);
    mf_en <= 1'b1;
    settle();
    chk("ss", {7'h00, ss_i}, 8'h00);
    @(posedge clk);
    spi_mst <= 1'b0;
    miso_o <= 1'b1;
    ext_e <= 8'h90;
    wr(8'h0c, 8'hff);
    settle();
    chk("pe_oe", pe_oe, 8'h2f);
    chk("spi", {sck_i, mosi_i, ss_i, 5'h00}, 8'ha0);
    wr(8'h0c, 8'h00);
    rd(8'h08, 8'hb0);
    wr(8'h0c, 8'hff);
    @(posedge clk);
    spi_en <= 1'b0;
    settle();
    chk("pe_oe", pe_oe, 8'hff);
    @(posedge clk);
    els0 <= 2'h1;
    els1 <= 2'h2;
    tdrv <= 2'b01;
    tout <= 2'b01;
    ser_en <= 1'b1;
    ext_e <= 8'h08;
    settle();
    chk("pe_oe", pe_oe, 8'hf5);
    chk("pe_out", pe_out & 8'h05, 8'h04);
    chk("tin", {5'h00, tin, rxd}, 8'h06);
    @(posedge clk);
    els0 <= 2'h0;
    els1 <= 2'h0;
    ser_en <= 1'b0;
    settle();
    chk("pe_oe", pe_oe, 8'hff);
    chk("rxd", {7'h00, rxd}, 8'h01);
    rst_chk();
    stop_test();
  end
endmodule
`default_nettype wire
